// ---- verilog/dnc_ctrl.sv ----
// channel binding, shared nco divisor and nco phase sync control
`default_nettype none
module dnc_ctrl
  import dnc_pkg::*;
(
  input  wire logic               clock,            // device clock, 10 MHz
  input  wire logic               resetn,           // sync reset, active low
  input  wire logic [11:0]        reg_addr,         // register byte address
  input  wire logic               reg_wr,           // write strobe, one cycle
  input  wire logic [7:0]         reg_wdata,        // write data
  input  wire logic               reg_rd,           // read strobe, one cycle
  output logic      [7:0]         reg_rdata,        // read data, next cycle
  input  wire logic [ADC_W-1:0]   adc_a_data,       // adc channel a samples
  input  wire logic [ADC_W-1:0]   adc_b_data,       // adc channel b samples
  input  wire logic               power_down_adc_a, // adc a powered down
  input  wire logic               power_down_adc_b, // adc b powered down
  input  wire logic               sync_n,           // link sync, active low
  input  wire logic               mf_boundary,      // multiframe boundary pulse
  input  wire logic               sysref,           // sysref level
  input  wire logic               enc_64b66b,       // 1 when 64b66b coding
  input  wire logic [PHASE_W-1:0] phase_offset_a,   // active preset offset, a
  input  wire logic [PHASE_W-1:0] phase_offset_b,   // active preset offset, b
  input  wire logic [ACC_W-1:0]   freq_word_a,      // active frequency word, a
  input  wire logic [ACC_W-1:0]   freq_word_b,      // active frequency word, b
  output logic      [ADC_W-1:0]   dig_a_data,       // digital channel a input
  output logic      [ADC_W-1:0]   dig_b_data,       // digital channel b input
  output logic                    dig_a_power_down, // digital a and its link off
  output logic                    dig_b_power_down, // digital b and its link off
  output logic                    link_sync_n,      // sync seen by the link
  output logic                    nco_phase_init,   // init happened this cycle
  output logic      [ACC_W-1:0]   nco_phase_a,      // accumulator, channel a
  output logic      [ACC_W-1:0]   nco_phase_b       // accumulator, channel b
);
  // every register of the block except the nco accumulators in dnc_nco_acc lives in this one struct
  typedef struct packed {
    logic [7:0]       binding;     // channel binding register
    logic [15:0]      rdiv;        // reference divisor register
    logic [7:0]       sync_ctrl;   // phase sync control register
    logic             sync_prev;   // last sync level
    logic             sysref_prev; // last sysref level
    logic             link_pend;   // sync rose, waiting for boundary
    logic             armed;       // sysref alignment armed
    logic             init;        // init pulse copy
    logic [7:0]       rdata;       // read data
    logic [ADC_W-1:0] dig_a;       // routed samples a
    logic [ADC_W-1:0] dig_b;       // routed samples b
    logic             pd_a;        // power down digital a
    logic             pd_b;        // power down digital b
    logic             link_sync;   // sync towards the link
  } dnc_state_s;

  dnc_state_s       st;            // registered state
  dnc_state_s       next_st;       // next state
  logic             fire;          // phase init this cycle
  logic             fire_link;     // boundary after a sync rise
  logic             fire_sysref;   // armed sysref rising edge
  logic             arm_wr;        // 0 then 1 seen on the arm bit
  logic [ACC_W-1:0] acc_phase [2]; // accumulator value per channel

  // edge detection and arming decode
  always_comb begin
    arm_wr      = reg_wr && reg_addr == ADDR_SYNC && reg_wdata[SYNC_NEXT_BIT] && !st.sync_ctrl[SYNC_NEXT_BIT];
    fire_link   = st.sync_ctrl[SYNC_LINK_BIT] && st.link_pend && mf_boundary;
    fire_sysref = st.armed && sysref && !st.sysref_prev;
    fire        = fire_link || fire_sysref;
  end

  // next state
  always_comb begin
    next_st             = st;
    // levels kept for edge detection on the next cycle
    next_st.sync_prev   = sync_n;
    next_st.sysref_prev = sysref;
    // init flag lines up with the accumulator load at the same edge
    next_st.init        = fire;
    // register writes; reserved bits store what is written
    if (reg_wr) begin
      unique case (reg_addr)
        ADDR_BIND:    next_st.binding    = reg_wdata;
        ADDR_RDIV_LO: next_st.rdiv[7:0]  = reg_wdata;
        ADDR_RDIV_HI: next_st.rdiv[15:8] = reg_wdata;
        ADDR_SYNC:    next_st.sync_ctrl  = reg_wdata;
        default:      next_st.rdiv       = st.rdiv; // unmapped, ignored
      endcase
    end
    // register reads, zero on unmapped
    if (reg_rd) begin
      unique case (reg_addr)
        ADDR_BIND:    next_st.rdata = st.binding;
        ADDR_RDIV_LO: next_st.rdata = st.rdiv[7:0];
        ADDR_RDIV_HI: next_st.rdata = st.rdiv[15:8];
        ADDR_SYNC:    next_st.rdata = st.sync_ctrl;
        default:      next_st.rdata = RD_UNMAPPED;
      endcase
    end
    // wait for first boundary after sync rises
    // a boundary in the rise cycle itself comes too early
    if (sync_n && !st.sync_prev && st.sync_ctrl[SYNC_LINK_BIT]) begin
      next_st.link_pend = 1'b1;
    end else if (fire_link || !st.sync_ctrl[SYNC_LINK_BIT]) begin
      next_st.link_pend = 1'b0;
    end
    // arming wins over a same-cycle firing
    if (arm_wr) begin
      next_st.armed = 1'b1;
    end else if (fire_sysref) begin
      next_st.armed = 1'b0;
    end
    next_st.dig_b = st.binding[BIND_B_BIT] ? adc_b_data : adc_a_data;
    next_st.dig_a = st.binding[BIND_A_BIT] ? adc_b_data : adc_a_data;
    // power down follows the bound adc
    next_st.pd_a = st.binding[BIND_A_BIT] ? power_down_adc_b : power_down_adc_a;
    next_st.pd_b = st.binding[BIND_B_BIT] ? power_down_adc_b : power_down_adc_a;
    // in 64b66b sync is kept from the link
    next_st.link_sync = enc_64b66b ? 1'b1 : sync_n;
  end

  // state register with reset values
  always_ff @(posedge clock) begin
    if (!resetn) begin
      st           <= '0;
      st.binding   <= BIND_RST;
      st.rdiv      <= RDIV_RST;
      st.sync_ctrl <= SYNC_RST;
      st.sync_prev <= 1'b1;
      st.link_sync <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // shared divisor and common load for both channels
  for (genvar ch = 0; ch < 2; ch++) begin : g_nco
    dnc_nco_acc u_acc (
      .clock        (clock),
      .resetn       (resetn),
      .load         (fire),
      .phase_offset (ch == 0 ? phase_offset_a : phase_offset_b),
      .freq_word    (ch == 0 ? freq_word_a : freq_word_b),
      .rdiv         (st.rdiv),
      .phase        (acc_phase[ch])
    );
  end

  // outputs come straight from the state flops
  assign nco_phase_a      = acc_phase[0];
  assign nco_phase_b      = acc_phase[1];
  assign reg_rdata        = st.rdata;
  assign dig_a_data       = st.dig_a;
  assign dig_b_data       = st.dig_b;
  assign dig_a_power_down = st.pd_a;
  assign dig_b_power_down = st.pd_b;
  assign link_sync_n      = st.link_sync;
  assign nco_phase_init   = st.init;

  // checks sit beside the logic they guard; all use sampled values
  // reset values of both registers
  a_bind_reset: assert property (@(posedge clock) !resetn |=> st.binding == 8'h02 && st.sync_ctrl == 8'h02)
    else $error("binding or sync control reset value wrong");

  a_route_b: assert property (@(posedge clock) disable iff (!resetn)
    $past(resetn) |-> dig_b_data == ($past(st.binding[1]) ? $past(adc_b_data) : $past(adc_a_data)))
    else $error("digital b source wrong");

  a_route_a: assert property (@(posedge clock) disable iff (!resetn)
    $past(resetn) |-> dig_a_data == ($past(st.binding[0]) ? $past(adc_b_data) : $past(adc_a_data)))
    else $error("digital a source wrong");

  a_bind_write: assert property (@(posedge clock) disable iff (!resetn)
    reg_wr && reg_addr == 12'h216 |=> st.binding == $past(reg_wdata))
    else $error("binding write not stored");

  a_pd_follow: assert property (@(posedge clock) disable iff (!resetn)
    $past(resetn) |-> dig_b_power_down == ($past(st.binding[1]) ? $past(power_down_adc_b) : $past(power_down_adc_a)))
    else $error("digital b power down wrong");

  a_pd_follow_a: assert property (@(posedge clock) disable iff (!resetn)
    $past(resetn) |-> dig_a_power_down == ($past(st.binding[0]) ? $past(power_down_adc_b) : $past(power_down_adc_a)))
    else $error("digital a power down wrong");

  a_rdiv_zero: assert property (@(posedge clock) !resetn ##1 resetn |-> st.rdiv == 16'h0000)
    else $error("divisor not zero after reset");

  a_link_fire: assert property (@(posedge clock) disable iff (!resetn)
    st.sync_ctrl[1] && st.link_pend && mf_boundary |=> nco_phase_init)
    else $error("boundary after sync did not init phase");

  a_link_drop: assert property (@(posedge clock) disable iff (!resetn)
    !st.sync_ctrl[1] |=> !st.link_pend)
    else $error("sync pending kept while link align is off");

  a_sync_hidden: assert property (@(posedge clock) disable iff (!resetn) enc_64b66b |=> link_sync_n)
    else $error("sync reached link in 64b66b");

  a_sync_pass: assert property (@(posedge clock) disable iff (!resetn)
    !enc_64b66b |=> link_sync_n == $past(sync_n))
    else $error("sync not passed to link in 8b10b");

  a_arm_seq: assert property (@(posedge clock) disable iff (!resetn)
    reg_wr && reg_addr == 12'h219 && reg_wdata[0] && !st.sync_ctrl[0] |=> st.armed)
    else $error("arming sequence did not arm");

  a_sysref_fire: assert property (@(posedge clock) disable iff (!resetn)
    st.armed && sysref && !st.sysref_prev |=> nco_phase_init)
    else $error("armed sysref edge did not init phase");

  a_sysref_once: assert property (@(posedge clock) disable iff (!resetn)
    st.armed && sysref && !st.sysref_prev && !arm_wr |=>
    !st.armed ##1 (st.armed || !nco_phase_init || $past(fire_link)))
    else $error("sysref alignment fired twice");

  a_init_both: assert property (@(posedge clock) disable iff (!resetn)
    nco_phase_init |-> nco_phase_a == {$past(phase_offset_a), 16'h0000} &&
    nco_phase_b == {$past(phase_offset_b), 16'h0000})
    else $error("accumulators not loaded together");
endmodule : dnc_ctrl
`default_nettype wire

// ---- verilog/dnc_pkg.sv ----
// constants for the channel binding, nco divisor and nco phase sync control block
`default_nettype none
package dnc_pkg;
  // register byte addresses
  localparam logic [11:0] ADDR_BIND    = 12'h216;
  localparam logic [11:0] ADDR_RDIV_LO = 12'h217;
  localparam logic [11:0] ADDR_RDIV_HI = 12'h218;
  localparam logic [11:0] ADDR_SYNC    = 12'h219;
  // reset values
  localparam logic [7:0]  BIND_RST     = 8'h02;
  localparam logic [15:0] RDIV_RST     = 16'h0000;
  localparam logic [7:0]  SYNC_RST     = 8'h02;
  localparam logic [7:0]  RD_UNMAPPED  = 8'h00;
  // field positions
  localparam int BIND_A_BIT    = 0;
  localparam int BIND_B_BIT    = 1;
  localparam int SYNC_NEXT_BIT = 0;
  localparam int SYNC_LINK_BIT = 1;
  // widths
  localparam int ADC_W   = 12;
  localparam int ACC_W   = 32;
  localparam int PHASE_W = 16;
  // divisor value above which spectral purity suffers
  localparam logic [15:0] RDIV_MAX_ADVISED = 16'h2000;
endpackage : dnc_pkg
`default_nettype wire

// ---- verilog/dnc_nco_acc.sv ----
// one nco phase accumulator with divisor wrap and phase load
`default_nettype none
module dnc_nco_acc
  import dnc_pkg::*;
(
  input  wire logic               clock,        // device clock
  input  wire logic               resetn,       // sync reset, active low
  input  wire logic               load,         // phase initialization pulse
  input  wire logic [PHASE_W-1:0] phase_offset, // active preset phase offset
  input  wire logic [ACC_W-1:0]   freq_word,    // active preset frequency word
  input  wire logic [15:0]        rdiv,         // shared reference divisor
  output logic      [ACC_W-1:0]   phase         // accumulator value
);
  typedef struct packed {
    logic [ACC_W-1:0] acc; // phase accumulator
  } dnc_acc_s;

  dnc_acc_s st;      // registered state
  dnc_acc_s next_st; // next state

  // next accumulator value
  always_comb begin
    logic [ACC_W:0] sum;
    logic [ACC_W:0] limit;
    sum     = {1'b0, st.acc} + {1'b0, freq_word};
    limit   = {1'b0, rdiv, 16'h0000};
    next_st = st;
    if (load) begin
      // offset is left justified into the accumulator
      next_st.acc = {phase_offset, 16'h0000};
    end else if (rdiv != 16'h0000 && sum >= limit) begin
      // nonzero divisor shortens the modulus so steps come out exact
      next_st.acc = ACC_W'(sum - limit);
    end else begin
      next_st.acc = sum[ACC_W-1:0];
    end
  end

  // state register
  always_ff @(posedge clock) begin
    if (!resetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign phase = st.acc;
endmodule : dnc_nco_acc
`default_nettype wire

// ---- tb/dnc_link_model.sv ----
// link receiver and sysref source model facing the nco_phase_sync_control control
`default_nettype none
module dnc_link_model #(
  parameter int MF_PERIOD = 8 // boundary spacing in device clocks
) (
  input  wire logic clock,       // device clock
  input  wire logic resetn,      // sync reset, active low
  input  wire logic sync_req,    // receiver asks for link sync
  input  wire logic sysref_go,   // high for as long as sysref should be high
  output logic      sync_n,      // link sync, active low
  output logic      mf_boundary, // multiframe boundary pulse
  output logic      sysref       // sysref level
);
  timeunit 1ns;
  timeprecision 1ns;
  int mf_cnt; // cycles since the last boundary
  // all lines launched from the device clock so the block sees clean edges
  always_ff @(posedge clock) begin
    if (!resetn) begin
      mf_cnt      <= 0;
      mf_boundary <= 1'b0;
      sync_n      <= 1'b1;
      sysref      <= 1'b0;
    end else begin
      mf_cnt      <= (mf_cnt == MF_PERIOD - 1) ? 0 : mf_cnt + 1;
      mf_boundary <= (mf_cnt == MF_PERIOD - 1);
      sync_n      <= ~sync_req;
      sysref      <= sysref_go;
    end
  end
endmodule : dnc_link_model
`default_nettype wire

// ---- tb/dnc_ctrl_tb.sv ----
// self-checking bench for the binding, divisor and nco_phase_sync_control block
`default_nettype none
module dnc_ctrl_tb
  import dnc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [15:0] RDIV_SET = 16'h2000; // largest advised divisor
  logic              clock = 1'b0, resetn = 1'b0;
  logic [11:0]       reg_addr = 12'h000;
  logic              reg_wr = 1'b0, reg_rd = 1'b0, enc_64b66b = 1'b0;
  logic [7:0]        reg_wdata = 8'h00, reg_rdata;
  logic [ADC_W-1:0]  adc_a_data = 12'h000, adc_b_data = 12'hfff, dig_a_data, dig_b_data;
  logic              power_down_adc_a = 1'b0, power_down_adc_b = 1'b0;
  logic              sync_n, mf_boundary, sysref, sync_req = 1'b0, sysref_go = 1'b0;
  logic [PHASE_W-1:0] phase_offset_a = 16'h1234, phase_offset_b = 16'h0678;
  logic [ACC_W-1:0]  freq_word_a = 32'h0400_0000, freq_word_b = 32'h0800_0000;
  logic              dig_a_power_down, dig_b_power_down, link_sync_n, nco_phase_init;
  logic [ACC_W-1:0]  nco_phase_a, nco_phase_b;
  int                n_fail = 0, n_tests = 0, cyc = 0;
  dnc_ctrl u_dut (.clock, .resetn, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .adc_a_data,
    .adc_b_data, .power_down_adc_a, .power_down_adc_b, .sync_n, .mf_boundary, .sysref, .enc_64b66b,
    .phase_offset_a, .phase_offset_b, .freq_word_a, .freq_word_b, .dig_a_data, .dig_b_data,
    .dig_a_power_down, .dig_b_power_down, .link_sync_n, .nco_phase_init, .nco_phase_a, .nco_phase_b);
  dnc_link_model #(.MF_PERIOD(8)) u_link (.clock, .resetn, .sync_req, .sysref_go, .sync_n, .mf_boundary, .sysref);
  // 100 ns period
  always #50 clock = ~clock;
  // moving samples so a stuck route cannot match by luck; also the hang guard
  always @(posedge clock) begin
    adc_a_data <= adc_a_data + 12'h001;
    adc_b_data <= adc_b_data - 12'h001;
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail++;
      summarize();
    end
  end
  task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", n, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr    <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [7:0] e, input string n);
    @(posedge clock);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clock);
    reg_rd   <= 1'b0;
    @(negedge clock);
    check(n, reg_rdata, e);
  endtask : rd
  // sync held low a few cycles, then released; link view checked while low
  task automatic sync_pulse(input logic low_seen);
    @(posedge clock);
    sync_req <= 1'b1;
    repeat (3) @(posedge clock);
    @(negedge clock);
    check("link_sync_n", link_sync_n, low_seen);
    @(posedge clock);
    sync_req <= 1'b0;
  endtask : sync_pulse
  task automatic sysref_pulse();
    @(posedge clock);
    sysref_go <= 1'b1;
    repeat (2) @(posedge clock);
    sysref_go <= 1'b0;
  endtask : sysref_pulse
  // bounded wait; leaves us at the negedge of the init cycle when one came
  task automatic wait_init(input logic exp, input string n);
    logic seen;
    seen = 1'b0;
    for (int i = 0; i < 40 && !seen; i++) begin
      @(negedge clock);
      seen = (nco_phase_init === 1'b1);
    end
    check(n, seen, exp);
  endtask : wait_init
  // four accumulation steps with the modulus taken from the divisor
  function automatic logic [31:0] acc(input logic [15:0] off, input logic [31:0] f);
    logic [32:0] s;
    s = {1'b0, off, 16'h0000};
    for (int i = 0; i < 4; i++) begin
      s = s + f;
      if (s >= {1'b0, RDIV_SET, 16'h0000}) s = s - {1'b0, RDIV_SET, 16'h0000};
    end
    return s[31:0];
  endfunction : acc
  task automatic summarize();
    if (n_fail == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : summarize
  initial begin
    repeat (6) @(posedge clock);
    resetn <= 1'b1;
    rd(ADDR_BIND, BIND_RST, "bind");
    rd(ADDR_RDIV_LO, 8'h00, "rdiv_lo");
    rd(ADDR_RDIV_HI, 8'h00, "rdiv_hi");
    rd(ADDR_SYNC, SYNC_RST, "sync_ctrl");
    rd(12'h21a, RD_UNMAPPED, "unmapped");
    // every binding against every power-down pair; link align stays on but sync is never requested meanwhile
    for (int b = 0; b < 4; b++) begin
      wr(ADDR_BIND, 8'(b));
      for (int p = 0; p < 4; p++) begin
        @(posedge clock);
        {power_down_adc_b, power_down_adc_a} <= 2'(p);
        repeat (2) @(negedge clock);
        check("dig_a", dig_a_data, b[0] ? 12'(adc_b_data + 1) : 12'(adc_a_data - 1));
        check("dig_b", dig_b_data, b[1] ? 12'(adc_b_data + 1) : 12'(adc_a_data - 1));
        check("pd_a", dig_a_power_down, p[b[0]]);
        check("pd_b", dig_b_power_down, p[b[1]]);
      end
    end
    @(posedge clock);
    power_down_adc_b <= 1'b0;
    power_down_adc_a <= 1'b0;
    wr(ADDR_BIND, BIND_RST);
    wr(ADDR_RDIV_LO, RDIV_SET[7:0]);
    wr(ADDR_RDIV_HI, RDIV_SET[15:8]);
    rd(ADDR_RDIV_HI, RDIV_SET[15:8], "rdiv_hi_rw");
    sync_pulse(1'b0);
    wait_init(1'b1, "init_link");
    check("load_a", nco_phase_a, {phase_offset_a, 16'h0000});
    check("load_b", nco_phase_b, {phase_offset_b, 16'h0000});
    repeat (4) @(negedge clock);
    check("acc_a", nco_phase_a, acc(phase_offset_a, freq_word_a));
    check("acc_b", nco_phase_b, acc(phase_offset_b, freq_word_b));
    @(posedge clock);
    enc_64b66b <= 1'b1;
    sync_pulse(1'b1);
    wait_init(1'b1, "init_66");
    wr(ADDR_SYNC, 8'h00);
    sync_pulse(1'b1);
    wait_init(1'b0, "link_off");
    wr(ADDR_SYNC, 8'h01);
    sysref_pulse();
    wait_init(1'b1, "sysref_first");
    sysref_pulse();
    wait_init(1'b0, "sysref_again");
    // new words need a fresh alignment before phase is deterministic again
    @(posedge clock);
    freq_word_a <= 32'h0200_0000;
    freq_word_b <= 32'h1000_0000;
    wr(ADDR_SYNC, 8'h00);
    wr(ADDR_SYNC, 8'h01);
    sysref_pulse();
    wait_init(1'b1, "sysref_rearm");
    check("reload_a", nco_phase_a, {phase_offset_a, 16'h0000});
    check("reload_b", nco_phase_b, {phase_offset_b, 16'h0000});
    repeat (4) @(negedge clock);
    check("acc2_a", nco_phase_a, acc(phase_offset_a, freq_word_a));
    check("acc2_b", nco_phase_b, acc(phase_offset_b, freq_word_b));
    // mid-run reset: registers back to defaults, arming dropped
    @(posedge clock);
    resetn      <= 1'b0;
    freq_word_a <= 32'h6000_0000;
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    rd(ADDR_BIND, BIND_RST, "bind_rst");
    rd(ADDR_RDIV_HI, 8'h00, "rdiv_rst");
    sysref_pulse();
    wait_init(1'b0, "rst_disarm");
    wr(ADDR_SYNC, 8'h01);
    sysref_pulse();
    wait_init(1'b1, "init_plain");
    repeat (4) @(negedge clock);
    check("acc_plain", nco_phase_a, 32'({phase_offset_a, 16'h0000} + 4 * freq_word_a));
    summarize();
  end
endmodule : dnc_ctrl_tb
`default_nettype wire
